// File: sipo_defs.svh
// Purpose: Shared constants for the serial latched output driver link
// Assumes: 20 MHz system clock on both ends
// Notes: Times in ns, counts derived in cycles
`ifndef SIPO_DEFS_SVH
`define SIPO_DEFS_SVH
`define SIPO_WIDTH 20
`define SIPO_CLK_NS 50
`define SIPO_SETUP_NS 75
`define SIPO_SETUP_CYC ((`SIPO_SETUP_NS + `SIPO_CLK_NS - 1) / `SIPO_CLK_NS)
`define SIPO_PULSE_NS 150
`define SIPO_PULSE_CYC ((`SIPO_PULSE_NS + `SIPO_CLK_NS - 1) / `SIPO_CLK_NS)
`define SIPO_STB_GAP_NS 300
`define SIPO_STB_GAP_CYC ((`SIPO_STB_GAP_NS + `SIPO_CLK_NS - 1) / `SIPO_CLK_NS)
`define SIPO_STB_WIDTH_NS 100
`define SIPO_STB_WIDTH_CYC ((`SIPO_STB_WIDTH_NS + `SIPO_CLK_NS - 1) / `SIPO_CLK_NS)
`define SIPO_CNT_W 4
`define SIPO_BIT_W 5
`endif

// File: sipo_pkg.sv
// Purpose: Types for the serial latched output driver link
// Assumes: Nothing beyond the defs header
// Notes: Host sequencer states
package sipo_pkg;
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SETUP,
    HS_HIGH,
    HS_LOW,
    HS_GAP,
    HS_STROBE
  } host_state_e;
  typedef logic [19:0] word_t;
endpackage

// File: sipo_link_if.sv
// Purpose: Pin-level link between host and driver
// Assumes: Host drives all four inputs, driver drives cascade out
// Notes: No clocking block
`timescale 1ns/10ps
interface sipo_link_if;
  logic ser_in;
  logic shift_clk;
  logic load_strobe;
  logic blank;
  logic cascade_out;
  modport host (output ser_in, output shift_clk, output load_strobe, output blank, input cascade_out);
  modport driver (input ser_in, input shift_clk, input load_strobe, input blank, output cascade_out);
endinterface

// File: sipo_driver.sv
// Purpose: Driver end: shift register, latch bank, blanked outputs
// Assumes: Pins are asynchronous to clk and are synchronised here
// Notes: Shift clock edge is detected after a three-stage synchroniser
`timescale 1ns/10ps
`include "sipo_defs.svh"
// Functional notes
// - Rising shift clock captures serial input
// - Stages shift toward cascade output
// - Host sets data before rising edge
// - Latches follow stages while strobe high
// - Host waits 300 ns before strobe
// - Bypassed latches need blanking during shifting
// - Blanking forces every output low
// - Blanking leaves latch contents unchanged
// - Unblanked outputs follow their latches
// - Host limits shift clock near 3.3 MHz
module sipo_driver (
  input wire logic clk,
  input wire logic rst,
  sipo_link_if.driver link,
  output logic [`SIPO_WIDTH-1:0] drive_out,
  output logic [`SIPO_WIDTH-1:0] latch_state
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic sclk_nxt;
  logic sclk_lvl_r;
  logic din_sample;
  logic stb_lvl_r;
  logic blk_lvl_r;
  logic [`SIPO_WIDTH-1:0] shreg_r;
  logic cascade_r;

  sipo_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) u_sipo_pin_sync_sclk (
    .clk(clk),
    .rst(rst),
    .pin(link.shift_clk),
    .stage(),
    .level_nxt(sclk_nxt),
    .level_r(sclk_lvl_r)
  );

  // Data taken at stage three, the same delay the clock edge sees
  sipo_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) u_sipo_pin_sync_din (
    .clk(clk),
    .rst(rst),
    .pin(link.ser_in),
    .stage(din_sample),
    .level_nxt(),
    .level_r()
  );

  sipo_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) u_sipo_pin_sync_stb (
    .clk(clk),
    .rst(rst),
    .pin(link.load_strobe),
    .stage(),
    .level_nxt(),
    .level_r(stb_lvl_r)
  );

  // Blanking starts high so outputs stay dark until the host speaks
  sipo_pin_sync #(
    .RESET_LEVEL(1'b1)
  ) u_sipo_pin_sync_blk (
    .clk(clk),
    .rst(rst),
    .pin(link.blank),
    .stage(),
    .level_nxt(),
    .level_r(blk_lvl_r)
  );

  wire shift_rise = sclk_nxt & ~sclk_lvl_r;
  wire [`SIPO_WIDTH-1:0] shreg_nxt = {shreg_r[`SIPO_WIDTH-2:0], din_sample};

  // ----------------------------------------
  // Shift register and latches
  // ----------------------------------------
  // Host setup and rate keep data stable across the sync delay
  always_ff @(posedge clk) begin
    if (rst) begin
      shreg_r <= '0;
    end else if (shift_rise) begin
      shreg_r <= shreg_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_state <= '0;
    end else if (stb_lvl_r) begin
      latch_state <= shreg_r;
    end
  end
  // Strobe low: latch_state keeps value blanking never enters here

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  wire [`SIPO_WIDTH-1:0] drive_nxt = blk_lvl_r ? '0 : latch_state;

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_out <= '0;
      cascade_r <= 1'b0;
    end else begin
      drive_out <= drive_nxt;
      cascade_r <= shreg_r[`SIPO_WIDTH-1];
    end
  end

  assign link.cascade_out = cascade_r;
endmodule

// ----------------------------------------
// Pin synchroniser
// ----------------------------------------
// A level counts once the last two stages agree, so a one-clock glitch never passes
module sipo_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic stage,
  output logic level_nxt,
  output logic level_r
);
  logic [2:0] sync_r;
  wire agree = sync_r[1] == sync_r[2];

  assign level_nxt = agree ? sync_r[2] : level_r;
  assign stage = sync_r[2];

  always_ff @(posedge clk) begin
    sync_r <= {sync_r[1:0], pin};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_r <= RESET_LEVEL;
    end else begin
      level_r <= level_nxt;
    end
  end
endmodule

// File: sipo_host.sv
// Purpose: Host end: serialises 20-bit words and strobes them in
// Assumes: Word source and link share clk
// Notes: Two-entry buffer absorbs a word while a frame is in flight
`timescale 1ns/10ps
`include "sipo_defs.svh"
module sipo_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SIPO_WIDTH-1:0] word_in,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic blank_req,
  input wire logic bypass,
  output logic busy,
  output logic cascade_seen,
  sipo_link_if.host link
);
  // ----------------------------------------
  // Two-entry buffer
  // ----------------------------------------
  sipo_pkg::word_t buf_mem [0:1];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  wire buf_full = count_r == 2'h2;
  wire buf_empty = count_r == 2'h0;
  // Registered ready gates the push, so nothing is taken unannounced after reset
  wire push = word_valid & word_ready & ~buf_full;
  logic pop;
  wire [1:0] count_nxt = count_r + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr_r] <= word_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      word_ready <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      count_r <= count_nxt;
      word_ready <= count_nxt != 2'h2;
    end
  end

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  sipo_pkg::host_state_e state_r;
  sipo_pkg::host_state_e state_nxt;
  logic [`SIPO_CNT_W-1:0] cnt_r;
  logic [`SIPO_BIT_W-1:0] bit_r;
  sipo_pkg::word_t shw_r;
  logic sclk_r;
  logic stb_r;
  logic blk_r;
  logic din_r;
  logic cas_r;

  wire cnt_done = cnt_r == '0;
  wire last_bit = bit_r == 5'(`SIPO_WIDTH - 1);
  assign pop = (state_r == sipo_pkg::HS_IDLE) & ~buf_empty;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sipo_pkg::HS_IDLE: if (pop) state_nxt = sipo_pkg::HS_SETUP;
      sipo_pkg::HS_SETUP: if (cnt_done) state_nxt = sipo_pkg::HS_HIGH;
      sipo_pkg::HS_HIGH: if (cnt_done) state_nxt = sipo_pkg::HS_LOW;
      sipo_pkg::HS_LOW: begin
        if (cnt_done) state_nxt = last_bit ? sipo_pkg::HS_GAP : sipo_pkg::HS_HIGH;
      end
      sipo_pkg::HS_GAP: if (cnt_done) state_nxt = sipo_pkg::HS_STROBE;
      sipo_pkg::HS_STROBE: if (cnt_done) state_nxt = sipo_pkg::HS_IDLE;
      default: state_nxt = sipo_pkg::HS_IDLE;
    endcase
  end

  // Low phase doubles as setup for the next bit, since 150 ns exceeds 75 ns
  wire load_cnt = state_nxt != state_r;
  wire [`SIPO_CNT_W-1:0] cnt_load =
    (state_nxt == sipo_pkg::HS_SETUP) ? `SIPO_CNT_W'(`SIPO_SETUP_CYC - 1) :
    (state_nxt == sipo_pkg::HS_GAP) ? `SIPO_CNT_W'(`SIPO_STB_GAP_CYC - 1) :
    (state_nxt == sipo_pkg::HS_STROBE) ? `SIPO_CNT_W'(`SIPO_STB_WIDTH_CYC - 1) :
    `SIPO_CNT_W'(`SIPO_PULSE_CYC - 1);
  wire low_done = (state_r == sipo_pkg::HS_LOW) & cnt_done;
  wire high_done = (state_r == sipo_pkg::HS_HIGH) & cnt_done;
  // Data moves on the falling shift edge: three cycles of setup (two before the first bit) and of hold
  wire [`SIPO_WIDTH-1:0] shw_nxt = pop ? buf_mem[rd_ptr_r] :
    high_done ? {shw_r[`SIPO_WIDTH-2:0], 1'b0} : shw_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= sipo_pkg::HS_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      shw_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= load_cnt ? cnt_load : cnt_r - `SIPO_CNT_W'(1);
      shw_r <= shw_nxt;
      if (pop) bit_r <= '0;
      else if (low_done) bit_r <= bit_r + 5'(1);
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // MSB first so word bit 19 ends in the last stage
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_r <= 1'b0;
      din_r <= 1'b0;
      stb_r <= 1'b0;
      blk_r <= 1'b1;
      cas_r <= 1'b0;
      busy <= 1'b0;
      cascade_seen <= 1'b0;
    end else begin
      din_r <= shw_nxt[`SIPO_WIDTH-1];
      sclk_r <= state_nxt == sipo_pkg::HS_HIGH;
      // Strobe only after the 300 ns gap, or held high in bypass
      stb_r <= bypass | (state_nxt == sipo_pkg::HS_STROBE);
      // Bypass blanks the whole frame
      blk_r <= blank_req | (bypass & (state_nxt != sipo_pkg::HS_IDLE));
      cas_r <= link.cascade_out;
      cascade_seen <= cas_r;
      busy <= state_nxt != sipo_pkg::HS_IDLE;
    end
  end

  assign link.shift_clk = sclk_r;
  assign link.ser_in = din_r;
  assign link.load_strobe = stb_r;
  assign link.blank = blk_r;
endmodule

// File: sipo_link_assertions.sv
// Purpose: Wire-level checks on the link between host and driver ends
// Assumes: One clk domain, rst synchronous and active high
// Notes: Cycle figures assume the 50 ns clock
`timescale 1ns/10ps
module sipo_link_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic ser_in,
  input wire logic shift_clk,
  input wire logic load_strobe,
  input wire logic blank,
  input wire logic cascade_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Link timing and framing
  // ----------------------------------------
  AST_SETUP: assert property ($rose(shift_clk) |-> $stable(ser_in)) else $error("data moved at shift edge");
  AST_HOLD: assert property ($rose(shift_clk) |=> $stable(ser_in) [*2]) else $error("data hold too short");
  AST_CLK_HIGH: assert property ($rose(shift_clk) |=> shift_clk [*2]) else $error("shift high too short");
  AST_CLK_LOW: assert property ($fell(shift_clk) |=> !shift_clk [*2]) else $error("shift low too short");
  // Six cycles is the 300 ns gap; the low phase only adds margin
  AST_STB_GAP: assert property ($fell(shift_clk) && !load_strobe |=> !load_strobe [*5]) else $error("strobe early");
  AST_STB_WIDTH: assert property ($rose(load_strobe) |=> load_strobe) else $error("strobe pulse too short");
  AST_BYPASS: assert property (shift_clk && load_strobe |-> blank) else $error("shift while unblanked");
  // Window covers the three-stage synchroniser plus the output register
  AST_CASCADE: assert property ($changed(cascade_out) |-> $past(shift_clk, 3) || $past(shift_clk, 4) ||
    $past(shift_clk, 5)) else $error("cascade moved without shifting");
  cover property ($rose(load_strobe));
  cover property ($rose(blank));
  cover property (shift_clk && load_strobe);
endmodule

// File: tb_serial_latched_output_driver.sv
// Purpose: Self-checking bench, host end driving driver end
// Assumes: Expected words noted by the sender, checked after each strobe
// Notes: Bypass frames are checked inline, strobe is held high and never falls
`timescale 1ns/10ps
module tb_serial_latched_output_driver;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sipo_pkg::word_t word_in = 20'h00000;
  logic word_valid = 1'b0;
  logic blank_req = 1'b0;
  logic bypass = 1'b0;
  logic word_ready;
  logic busy;
  logic cascade_seen;
  sipo_pkg::word_t drive_out;
  sipo_pkg::word_t latch_state;
  sipo_pkg::word_t exp_q[$];
  sipo_pkg::word_t got_w;
  sipo_pkg::word_t last_w;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  sipo_link_if u_sipo_link_if ();
  sipo_host u_sipo_host (.clk(clk), .rst(rst), .word_in(word_in), .word_valid(word_valid),
    .word_ready(word_ready), .blank_req(blank_req), .bypass(bypass), .busy(busy),
    .cascade_seen(cascade_seen), .link(u_sipo_link_if));
  sipo_driver u_sipo_driver (.clk(clk), .rst(rst), .link(u_sipo_link_if), .drive_out(drive_out),
    .latch_state(latch_state));
  sipo_link_assertions u_sipo_link_assertions (.clk(clk), .rst(rst), .ser_in(u_sipo_link_if.ser_in),
    .shift_clk(u_sipo_link_if.shift_clk), .load_strobe(u_sipo_link_if.load_strobe),
    .blank(u_sipo_link_if.blank), .cascade_out(u_sipo_link_if.cascade_out));
  always #25 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Valid stays up so bursts go back to back; caller drops it
  task automatic send(input sipo_pkg::word_t w);
    word_in = w;
    word_valid = 1'b1;
    while (word_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    if (!bypass) exp_q.push_back(w);
    last_w = w;
    #1;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    forever begin
      @(negedge u_sipo_link_if.load_strobe);
      repeat (8) @(posedge clk);
      #2;
      if (exp_q.size() > 0) begin
        got_w = exp_q.pop_front();
        check(latch_state, got_w);
        check(drive_out, got_w);
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(86));
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    // Fourth word must wait for buffer room
    send(20'hFFFFF);
    send(20'h00001);
    send(20'h80000);
    for (int i = 0; i < 4; i++) send(sipo_pkg::word_t'($urandom));
    word_valid = 1'b0;
    wait (exp_q.size() == 0 && busy === 1'b0);
    @(posedge clk);
    $display("burst test done");
    #1 blank_req = 1'b1;
    repeat (10) @(posedge clk);
    #1 check(drive_out, 20'h00000);
    check(latch_state, last_w);
    check({19'h00000, cascade_seen}, {19'h00000, last_w[19]});
    blank_req = 1'b0;
    repeat (10) @(posedge clk);
    #1 check(drive_out, last_w);
    $display("blank test done");
    bypass = 1'b1;
    send(sipo_pkg::word_t'($urandom));
    word_valid = 1'b0;
    wait (busy === 1'b1);
    wait (busy === 1'b0);
    repeat (10) @(posedge clk);
    #1 check(latch_state, last_w);
    check(drive_out, last_w);
    $display("bypass test done");
    end_of_test();
  end
endmodule
